// File: pis_params.svh
// Purpose: constants for the process interrupt and stall unit
// Assumes: 200 MHz clock, 5 ns period
// Notes: positions are 1-based priority numbers, bit index is position minus one
`ifndef PIS_PARAMS_SVH
`define PIS_PARAMS_SVH

`define PIS_NUM_REQ 20
`define PIS_POS_PWR_ON 1
`define PIS_POS_PWR_OUT 2
`define PIS_POS_WDOG 5
`define PIS_POS_RTC 6
`define PIS_POS_ADC 7
`define PIS_POS_ETC 8
`define PIS_POS_RX_FIRST 9
`define PIS_POS_RX_LAST 12
`define PIS_POS_RELAY 13
`define PIS_POS_AOUT 14
`define PIS_POS_PUNCH 15
`define PIS_POS_ALARM_PR 16
`define PIS_POS_LOG_PR 17
`define PIS_POS_CONSOLE 18
`define PIS_POS_MAIN_PNL 19
`define PIS_POS_AUX_PNL 20
`define PIS_CLK_MHZ 200
`define PIS_WDOG_SEC 5
`define PIS_RTC_SEC 1
`define PIS_CYC_PER_SEC (`PIS_CLK_MHZ * 1000000)
`define PIS_WDOG_CYC (`PIS_WDOG_SEC * `PIS_CYC_PER_SEC)
`define PIS_RTC_CYC (`PIS_RTC_SEC * `PIS_CYC_PER_SEC)
`define PIS_WORD_W 24

`endif

// File: pis_pkg.sv
// Purpose: types for the process interrupt and stall unit
// Assumes: pis_params.svh holds the numbers
// Notes: none
`default_nettype none
package pis_pkg;
    typedef logic [19:0] pis_req_t;
    typedef logic [4:0] pis_pos_t;
    typedef enum logic [2:0] {
        PIS_RUN = 3'b001,
        PIS_OFFER = 3'b010,
        PIS_SERVE = 3'b100
    } pis_state_e;
endpackage : pis_pkg
`default_nettype wire

// File: pis_tick_if.sv
// Purpose: carries the watchdog and real-time tick events between modules
// Assumes: one clock
// Notes: pulses are one cycle wide
`timescale 1ns/100ps
`default_nettype none
interface pis_tick_if;
    logic wdog_clear;
    logic wdog_fire;
    logic rtc_tick;
    modport timer (input wdog_clear, output wdog_fire, output rtc_tick);
    modport core (output wdog_clear, input wdog_fire, input rtc_tick);
endinterface : pis_tick_if
`default_nettype wire

// File: pis_timers.sv
// Purpose: watchdog and one-second real-time tick counters
// Assumes: single 200 MHz clock
// Notes: watchdog restarts at zero after firing so it keeps guarding
`timescale 1ns/100ps
`default_nettype none
`include "pis_params.svh"
module pis_timers
    import pis_pkg::*;
#(
    parameter int WDOG_CYC = `PIS_WDOG_CYC,
    parameter int RTC_CYC = `PIS_RTC_CYC
) (
    input wire logic clk,
    input wire logic rstn,
    pis_tick_if.timer tk
);
    logic [31:0] wdog_cnt;
    logic [31:0] rtc_cnt;
    wire wdog_end = (wdog_cnt == 32'(WDOG_CYC - 1));
    wire rtc_end = (rtc_cnt == 32'(RTC_CYC - 1));

    // watchdog: software clear wins, else count to the limit
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wdog_cnt <= 32'h0000_0000;
        end else if (tk.wdog_clear || wdog_end) begin
            wdog_cnt <= 32'h0000_0000;
        end else begin
            wdog_cnt <= wdog_cnt + 32'h0000_0001;
        end
    end

    // free-running one-second divider
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rtc_cnt <= 32'h0000_0000;
        end else if (rtc_end) begin
            rtc_cnt <= 32'h0000_0000;
        end else begin
            rtc_cnt <= rtc_cnt + 32'h0000_0001;
        end
    end

    assign tk.wdog_fire = wdog_end && !tk.wdog_clear;
    assign tk.rtc_tick = rtc_end;

    a_wdog_fire_gap: assert property (@(posedge clk) disable iff (!rstn)
        tk.wdog_clear |=> !tk.wdog_fire)
        else $error("watchdog fired right after clear");
endmodule : pis_timers
`default_nettype wire

// File: pis_unit.sv
// Purpose: priority interrupt scanner with watchdog, tick and stall logic
// Assumes: one 200 MHz clock, core samples the offer between instructions
// Notes: pin source events pass through three flops; watchdog and tick events do not
`timescale 1ns/100ps
`default_nettype none
`include "pis_params.svh"
module pis_unit
    import pis_pkg::*;
#(
    parameter int WDOG_CYC = `PIS_WDOG_CYC,
    parameter int RTC_CYC = `PIS_RTC_CYC
) (
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic POWER_ON,
    input wire logic POWER_LOSS,
    input wire logic [1:0] BUFFER_REQ,
    input wire logic ADC_DONE,
    input wire logic ETC_DONE,
    input wire logic [3:0] REACTOR_REQ,
    input wire logic RELAY_DONE,
    input wire logic AOUT_DONE,
    input wire logic PUNCH_DONE,
    input wire logic ALARM_PR_DONE,
    input wire logic LOG_PR_DONE,
    input wire logic CONSOLE_REQ,
    input wire logic MAIN_PANEL_SW,
    input wire logic AUX_PANEL_SW,
    input wire logic SUPPLY_FAIL,
    input wire logic SUPPLY_FAIL_HALT,
    input wire logic INHIBIT_BTN,
    input wire logic STALL_CLEAR,
    input wire logic INSTR_DONE,
    input wire logic INSTR_EXCEPT,
    input wire logic SERVICE_ACK,
    input wire logic SERVICE_RETURN,
    input wire logic WDOG_CLEAR,
    input wire logic MEM_CHECK,
    input wire logic [23:0] MEM_DATA,
    input wire logic MEM_PARITY,
    input wire logic [23:0] OUT_DATA_IN,
    input wire logic OUT_WRITE,
    output logic IRQ_VALID,
    output logic [4:0] IRQ_POS,
    output logic STALL,
    output logic HALT,
    output logic PARITY_ERR,
    output logic [23:0] OUT_DATA,
    output logic OUT_STROBE,
    output logic [19:0] PENDING
);
    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic [23:0] raw_ev;
    logic [23:0] s1, s2, s3;
    logic [19:0] src_ev;
    logic [19:0] pend;
    logic stall_q, halt_q, parity_q;
    logic [23:0] out_q;
    logic out_stb;
    pis_state_e state;
    pis_tick_if tk ();

    // pin events, bit index is position minus one
    assign raw_ev = {SUPPLY_FAIL_HALT, SUPPLY_FAIL, INHIBIT_BTN, STALL_CLEAR,
        AUX_PANEL_SW, MAIN_PANEL_SW, CONSOLE_REQ, LOG_PR_DONE, ALARM_PR_DONE,
        PUNCH_DONE, AOUT_DONE, RELAY_DONE, REACTOR_REQ, ETC_DONE, ADC_DONE,
        1'b0, 1'b0, BUFFER_REQ, POWER_LOSS, POWER_ON};

    // three flops; a level counts once the second and third agree
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            s1 <= 24'h00_0000;
            s2 <= 24'h00_0000;
            s3 <= 24'h00_0000;
        end else begin
            s1 <= raw_ev;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // a pin change counts only once the second and third flops agree; the
    // held level bridges the cycle in which they differ, so one slow edge
    // gives exactly one event and reset never leaves a false one behind
    logic [23:0] agreed;
    wire [23:0] next_agreed = (s2 & s3) | (agreed & (s2 | s3));
    wire [23:0] ev_edge = s2 & s3 & ~agreed;
    wire [23:0] lvl = s2 & s3;

    // held agreed level of every pin
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            agreed <= 24'h00_0000;
        end else begin
            agreed <= next_agreed;
        end
    end

    // ------------------------------------------------------------
    // timers
    // ------------------------------------------------------------
    assign tk.wdog_clear = WDOG_CLEAR;

    pis_timers #(
        .WDOG_CYC(WDOG_CYC),
        .RTC_CYC(RTC_CYC)
    ) u_timers (
        .clk(CLK),
        .rstn(RSTN),
        .tk(tk)
    );

    // ------------------------------------------------------------
    // request latch and priority scan
    // ------------------------------------------------------------
    // source map: positions 1,2,3,4 from pins, 5 watchdog, 6 tick, 7..20 pins
    assign src_ev = {ev_edge[19:6], tk.rtc_tick, tk.wdog_fire, ev_edge[3:0]};

    // lowest index set wins, since position one is highest
    function automatic pis_pos_t top_pos(input pis_req_t r);
        pis_pos_t p;
        p = 5'd0;
        for (int i = `PIS_NUM_REQ - 1; i >= 0; i--) begin
            if (r[i]) begin
                p = 5'(i + 1);
            end
        end
        return p;
    endfunction : top_pos

    wire [4:0] best = top_pos(pend);
    wire boundary = INSTR_DONE && !INSTR_EXCEPT && !halt_q;
    wire take = (state == PIS_OFFER) && SERVICE_ACK;
    wire [19:0] clr_mask = take ? (20'h0_0001 << (IRQ_POS - 5'd1)) : 20'h0_0000;

    // set wins over the service clear so a new event is never dropped
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            pend <= 20'h0_0000;
        end else begin
            pend <= (pend & ~clr_mask) | src_ev;
        end
    end

    // offer at a boundary, hold until the core takes it, then wait for return
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            state <= PIS_RUN;
            IRQ_POS <= 5'd0;
        end else begin
            unique case (state)
                PIS_RUN: begin
                    if (boundary && best != 5'd0) begin
                        state <= PIS_OFFER;
                        IRQ_POS <= best;
                    end
                end
                PIS_OFFER: begin
                    if (SERVICE_ACK) begin
                        state <= PIS_SERVE;
                    end
                end
                PIS_SERVE: begin
                    if (SERVICE_RETURN) begin
                        state <= PIS_RUN;
                    end
                end
            endcase
        end
    end

    assign IRQ_VALID = (state == PIS_OFFER);
    assign PENDING = pend;

    // ------------------------------------------------------------
    // parity check and stall
    // ------------------------------------------------------------
    wire parity_bad = MEM_CHECK && ((^MEM_DATA) != MEM_PARITY);
    wire halt_cause = parity_bad || lvl[23];
    wire stall_cause = halt_cause || lvl[22] || lvl[21] || tk.wdog_fire;
    wire op_clear = ev_edge[20];

    // latched stall; a cause in the clear cycle keeps it set
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            stall_q <= 1'b0;
            halt_q <= 1'b0;
            parity_q <= 1'b0;
        end else begin
            stall_q <= stall_cause || (stall_q && !op_clear);
            halt_q <= halt_cause || (halt_q && !op_clear);
            parity_q <= parity_bad || (parity_q && !op_clear);
        end
    end

    assign STALL = stall_q;
    assign HALT = halt_q;
    assign PARITY_ERR = parity_q;

    // process output register; writes dropped while stalled
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            out_q <= 24'h00_0000;
            out_stb <= 1'b0;
        end else begin
            out_stb <= OUT_WRITE && !stall_q;
            if (OUT_WRITE && !stall_q) begin
                out_q <= OUT_DATA_IN;
            end
        end
    end

    assign OUT_DATA = out_q;
    assign OUT_STROBE = out_stb;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // offer walk: a boundary with work, the standing offer, then the take
    sequence s_boundary_work;
        state == PIS_RUN && boundary && pend != 20'h0_0000;
    endsequence

    sequence s_offer;
        IRQ_VALID && !SERVICE_ACK;
    endsequence

    sequence s_take;
        IRQ_VALID && SERVICE_ACK;
    endsequence

    // positions ranked above the offered one; only read while offering
    wire [19:0] higher_mask = (20'h0_0001 << (IRQ_POS - 5'd1)) - 20'h0_0001;

    a_offer_is_best: assert property (@(posedge CLK) disable iff (!RSTN)
        $rose(IRQ_VALID) |-> pend[IRQ_POS - 5'd1])
        else $error("offered position not pending");
    a_offer_top_prio: assert property (@(posedge CLK) disable iff (!RSTN)
        $rose(IRQ_VALID) |-> ($past(pend) & higher_mask) == 20'h0_0000)
        else $error("higher position was pending");
    a_offer_held: assert property (@(posedge CLK) disable iff (!RSTN)
        s_offer |=> IRQ_VALID && $stable(IRQ_POS))
        else $error("offer dropped before ack");
    a_offer_at_edge: assert property (@(posedge CLK) disable iff (!RSTN)
        s_boundary_work |=> IRQ_VALID)
        else $error("pending request not offered");
    a_no_offer_idle: assert property (@(posedge CLK) disable iff (!RSTN)
        (state == PIS_RUN && !boundary) |=> !IRQ_VALID)
        else $error("offer without boundary");
    a_take_ends: assert property (@(posedge CLK) disable iff (!RSTN)
        s_take |=> !IRQ_VALID && state == PIS_SERVE)
        else $error("offer kept after ack");
    a_ack_clears_flag: assert property (@(posedge CLK) disable iff (!RSTN)
        (IRQ_VALID && SERVICE_ACK && !src_ev[IRQ_POS - 5'd1]) |=> !pend[IRQ_POS - 5'd1])
        else $error("serviced flag not cleared");
    a_return_rescan: assert property (@(posedge CLK) disable iff (!RSTN)
        (state == PIS_SERVE && SERVICE_RETURN) |=> state == PIS_RUN)
        else $error("no rescan after return");
    a_pend_sets: assert property (@(posedge CLK) disable iff (!RSTN)
        (src_ev != 20'h0_0000) |=> (pend & $past(src_ev)) == $past(src_ev))
        else $error("source event not latched");
    a_event_kept: assert property (@(posedge CLK) disable iff (!RSTN)
        tk.rtc_tick |=> pend[5])
        else $error("tick request lost");
    a_stall_on_wdog: assert property (@(posedge CLK) disable iff (!RSTN)
        tk.wdog_fire |=> STALL && pend[4])
        else $error("watchdog did not stall");
    a_stall_holds: assert property (@(posedge CLK) disable iff (!RSTN)
        (STALL && !op_clear) |=> STALL)
        else $error("stall released without clear");
    a_stall_clears: assert property (@(posedge CLK) disable iff (!RSTN)
        (op_clear && !stall_cause) |=> !STALL && !HALT && !PARITY_ERR)
        else $error("operator clear ignored");
    a_stall_blocks: assert property (@(posedge CLK) disable iff (!RSTN)
        STALL |=> !OUT_STROBE)
        else $error("output changed during stall");
    a_out_passes: assert property (@(posedge CLK) disable iff (!RSTN)
        (OUT_WRITE && !STALL) |=> OUT_STROBE && OUT_DATA == $past(OUT_DATA_IN))
        else $error("free output write lost");
    a_parity_halt: assert property (@(posedge CLK) disable iff (!RSTN)
        parity_bad |=> HALT && STALL && PARITY_ERR)
        else $error("parity error did not halt");
    a_halt_no_offer: assert property (@(posedge CLK) disable iff (!RSTN)
        (HALT && state == PIS_RUN) |=> !IRQ_VALID)
        else $error("offer made while halted");
    // inhibit alone stalls but must leave the processor running
    a_inhibit_stall: assert property (@(posedge CLK) disable iff (!RSTN)
        (lvl[21] && !halt_cause && !HALT) |=> STALL && !HALT)
        else $error("inhibit did not stall or halted");
endmodule : pis_unit
`default_nettype wire

// File: pis_core_model.sv
// Purpose: behavioural processor core facing the interrupt unit
// Assumes: shares the unit's clock
// Notes: service delay alternates prompt and slow
`timescale 1ns/100ps
`default_nettype none
module pis_core_model (
    input wire logic clk,
    input wire logic rstn,
    input wire logic en,
    input wire logic exc,
    input wire logic wd_en,
    input wire logic irq_valid,
    input wire logic [4:0] irq_pos,
    input wire logic halt,
    output logic instr_done,
    output logic instr_except,
    output logic service_ack,
    output logic service_return,
    output logic wdog_clear,
    output logic svc_stb,
    output logic [4:0] svc_pos
);
    logic [3:0] cnt;
    logic [3:0] fc;
    logic serving;
    logic slow;
    // boundaries every other cycle, kicks every 16, ack then return
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            {instr_done, instr_except, service_ack, service_return, wdog_clear} <= '0;
            {svc_stb, svc_pos, cnt, fc, serving, slow} <= '0;
        end else begin
            fc <= fc + 4'h1;
            instr_done <= en && !halt && !instr_done;
            instr_except <= exc;
            wdog_clear <= wd_en && fc == 4'h0;
            service_ack <= 1'b0;
            svc_stb <= 1'b0;
            service_return <= 1'b0;
            if (serving || irq_valid) begin
                cnt <= cnt + 4'h1;
            end
            // serving guard: the offer still stands in the ack cycle
            if (!serving && irq_valid && cnt == (slow ? 4'h5 : 4'h0)) begin
                service_ack <= 1'b1;
                svc_stb <= 1'b1;
                svc_pos <= irq_pos;
                slow <= !slow;
                serving <= 1'b1;
                cnt <= 4'h0;
            end
            if (serving && cnt == 4'h3) begin
                service_return <= 1'b1;
                serving <= 1'b0;
                cnt <= 4'h0;
            end
        end
    end
endmodule : pis_core_model
`default_nettype wire

// File: process_interrupt_stall_unit_tb.sv
// Purpose: self-checking bench for the interrupt, watchdog and stall unit
// Assumes: shortened watchdog and tick counts
// Notes: services and output writes are scored through queues
`timescale 1ns/100ps
`default_nettype none
module process_interrupt_stall_unit_tb;
    localparam int WDOG = 300;
    localparam int RTC = 8000;
    logic clk, rstn, en, exc, wd_en, mem_check, mem_parity, out_write, stall_clear;
    logic idone, iexc, ack, ret, wclr, svc_stb, irq_valid, stall, halt, perr, ostb;
    logic [2:0] cause;
    logic [4:0] irq_pos, svc_pos;
    logic [19:0] pins, pending;
    logic [23:0] mem_data, out_data_in, out_data, d;
    logic [23:0] svc_q[$];
    logic [23:0] out_q[$];
    int bad_count = 0;
    int num_checks = 0;
    int cycles, t0, t1;
    pis_unit #(.WDOG_CYC(WDOG), .RTC_CYC(RTC)) pis_unit_inst (
        .CLK(clk), .RSTN(rstn), .POWER_ON(pins[0]), .POWER_LOSS(pins[1]),
        .BUFFER_REQ(pins[3:2]), .ADC_DONE(pins[6]), .ETC_DONE(pins[7]),
        .REACTOR_REQ(pins[11:8]), .RELAY_DONE(pins[12]), .AOUT_DONE(pins[13]),
        .PUNCH_DONE(pins[14]), .ALARM_PR_DONE(pins[15]), .LOG_PR_DONE(pins[16]),
        .CONSOLE_REQ(pins[17]), .MAIN_PANEL_SW(pins[18]), .AUX_PANEL_SW(pins[19]),
        .SUPPLY_FAIL(cause[1]), .SUPPLY_FAIL_HALT(cause[2]), .INHIBIT_BTN(cause[0]),
        .STALL_CLEAR(stall_clear), .INSTR_DONE(idone), .INSTR_EXCEPT(iexc),
        .SERVICE_ACK(ack), .SERVICE_RETURN(ret), .WDOG_CLEAR(wclr),
        .MEM_CHECK(mem_check), .MEM_DATA(mem_data), .MEM_PARITY(mem_parity),
        .OUT_DATA_IN(out_data_in), .OUT_WRITE(out_write), .IRQ_VALID(irq_valid),
        .IRQ_POS(irq_pos), .STALL(stall), .HALT(halt), .PARITY_ERR(perr),
        .OUT_DATA(out_data), .OUT_STROBE(ostb), .PENDING(pending));
    pis_core_model pis_core_model_inst (
        .clk(clk), .rstn(rstn), .en(en), .exc(exc), .wd_en(wd_en),
        .irq_valid(irq_valid), .irq_pos(irq_pos), .halt(halt), .instr_done(idone),
        .instr_except(iexc), .service_ack(ack), .service_return(ret),
        .wdog_clear(wclr), .svc_stb(svc_stb), .svc_pos(svc_pos));
    task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
        num_checks++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : tally_and_finish
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    // bounded wait for the model to take every queued service
    task automatic drain;
        int n;
        n = 0;
        while (svc_q.size() != 0 && n < 3000) begin
            @(posedge clk);
            n++;
        end
        chk("services left", 24'h00_0000, 24'(svc_q.size()));
        cyc(2);
    endtask : drain
    // latch a set of pin events with the core parked, then serve them
    task automatic round(input logic [19:0] m);
        en <= 1'b0;
        pins <= m;
        cyc(8);
        @(negedge clk);
        chk("pending", 24'(m), 24'(pending));
        for (int p = 0; p < 20; p++) begin
            if (m[p]) svc_q.push_back(24'(p + 1));
        end
        @(posedge clk);
        pins <= 20'h0_0000;
        en <= 1'b1;
        drain();
        @(negedge clk);
        chk("pending after", 24'h00_0000, 24'(pending));
        @(posedge clk);
    endtask : round
    task automatic out_wr(input logic keep);
        logic [23:0] v;
        v = 24'($urandom);
        if (keep) out_q.push_back(v);
        out_data_in <= v;
        out_write <= 1'b1;
        @(posedge clk);
        out_write <= 1'b0;
        cyc(2);
    endtask : out_wr
    // cycle stamp of the next tick request, with the core parked
    task automatic tick_at(output int t);
        int n;
        n = 0;
        en <= 1'b0;
        while (pending[5] !== 1'b1 && n < 9000) begin
            @(posedge clk);
            n++;
        end
        t = cycles;
    endtask : tick_at
    task automatic unstall;
        stall_clear <= 1'b1;
        cyc(6);
        stall_clear <= 1'b0;
        cyc(6);
        @(negedge clk);
        chk("stall cleared", 24'h00_0000, 24'({stall, halt, perr}));
        @(posedge clk);
    endtask : unstall
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) cycles <= cycles + 1;
    // watcher: every result takes the oldest note; an empty queue fails
    always @(posedge clk) begin
        if (svc_stb === 1'b1) chk("service", svc_q.size() ? svc_q.pop_front() : 'x, 24'(svc_pos));
        if (ostb === 1'b1) chk("out data", out_q.size() ? out_q.pop_front() : 'x, out_data);
    end
    // hang guard, about two and a half times the expected run
    initial begin
        #200000;
        bad_count++;
        tally_and_finish();
    end
    initial begin
        void'($urandom(32'hd685_d34a));
        {rstn, en, exc, pins, cause, stall_clear, mem_check, mem_parity} = '0;
        {mem_data, out_data_in, out_write} = '0;
        wd_en = 1'b1;
        cycles = 0;
        cyc(6);
        @(negedge clk);
        chk("reset flags", 24'h00_0000, 24'({irq_valid, stall, halt, perr, ostb}));
        chk("reset pending", 24'h00_0000, 24'(pending));
        @(posedge clk);
        rstn <= 1'b1;
        cyc(4);
        round(20'hF_FFCF);
        repeat (3) round(20'($urandom) & 20'hF_FFCF);
        // no offer at excepted boundaries
        en <= 1'b0;
        exc <= 1'b1;
        pins <= 20'h4_0000;
        cyc(8);
        en <= 1'b1;
        t0 = 0;
        repeat (30) begin
            @(posedge clk);
            if (irq_valid === 1'b1) t0++;
        end
        chk("excepted offer", 24'h00_0000, 24'(t0));
        svc_q.push_back(24'h00_0013);
        exc <= 1'b0;
        pins <= 20'h0_0000;
        drain();
        // stall causes: inhibit, supply, halting supply, bad parity
        for (int i = 0; i < 4; i++) begin
            out_wr(1'b1);
            d = 24'($urandom);
            mem_data <= d;
            mem_parity <= ^d ^ (i == 3);
            mem_check <= 1'b1;
            if (i < 3) cause <= 3'(1 << i);
            @(posedge clk);
            mem_check <= 1'b0;
            cyc(6);
            cause <= 3'b000;
            cyc(6);
            @(negedge clk);
            chk("stall held", 24'h00_0001, 24'(stall));
            chk("halt", 24'(i >= 2), 24'(halt));
            chk("parity flag", 24'(i == 3), 24'(perr));
            @(posedge clk);
            out_wr(1'b0);
            unstall();
        end
        // starve the watchdog
        svc_q.push_back(24'h00_0005);
        wd_en <= 1'b0;
        t0 = 0;
        while (stall !== 1'b1 && t0 < 600) begin
            @(posedge clk);
            t0++;
        end
        chk("watchdog span", 24'h00_0001, 24'(t0 >= WDOG - 20 && t0 <= WDOG + 5));
        chk("watchdog halt", 24'h00_0000, 24'(halt));
        wd_en <= 1'b1;
        drain();
        unstall();
        // tick spacing from two successive tick requests
        tick_at(t0);
        svc_q.push_back(24'h00_0006);
        en <= 1'b1;
        drain();
        tick_at(t1);
        chk("tick period", 24'(RTC), 24'(t1 - t0));
        svc_q.push_back(24'h00_0006);
        en <= 1'b1;
        drain();
        tally_and_finish();
    end
endmodule : process_interrupt_stall_unit_tb
`default_nettype wire
